// file: include/rxfmt_pkg.sv
// rxfmt_pkg: constants for the receive output bus formatter.
// assumes one channel per formatter instance and a 32-bit apb slave.
package rxfmt_pkg;

	// ----------------------------------------------------------------
	// three-level select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] LVL_BAD = 2'h3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam int CTRL_DEC_LSB = 0;
	localparam int CTRL_PAR_LSB = 2;
	localparam int CTRL_FRM_LSB = 4;
	localparam int CTRL_CKS_LSB = 6;
	localparam int CTRL_HALF_BIT = 8;
	localparam int CTRL_FEN_BIT = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0055;
	localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;
	localparam int STAT_DATA_LSB = 0;
	localparam int STAT_ST_LSB = 8;
	localparam int STAT_PAR_BIT = 11;
	localparam int STAT_CLK_BIT = 12;
	localparam int STAT_PIPE_BIT = 13;
	localparam int STAT_OEN_BIT = 14;

	// ----------------------------------------------------------------
	// decoded status codes
	// ----------------------------------------------------------------
	localparam logic [2:0] ST_NORMAL = 3'h0;
	localparam logic [2:0] ST_SPECIAL = 3'h1;
	localparam logic [2:0] ST_BUF_ERR = 3'h2;
	localparam logic [2:0] ST_FRAME = 3'h3;
	localparam logic [2:0] ST_CODE_VIOL = 3'h4;
	localparam logic [2:0] ST_UNLOCK = 3'h5;
	localparam logic [2:0] ST_DISP_ERR = 3'h6;
	localparam logic [2:0] ST_INVALID = 3'h7;

	// ----------------------------------------------------------------
	// condition vector positions and link-side bundle width
	// ----------------------------------------------------------------
	localparam int COND_SPECIAL = 0;
	localparam int COND_DISP = 1;
	localparam int COND_FRAME = 2;
	localparam int COND_CODEV = 3;
	localparam int COND_INVALID = 4;
	localparam int COND_BUF = 5;
	localparam int COND_PLL = 6;
	localparam int LINK_W = 31;

endpackage : rxfmt_pkg

// file: hw/rxfmt_parity.sv
// rxfmt_parity: odd parity over the bits chosen by the parity mode.
// assumes inputs are the next output register contents.
`timescale 1ns/1ps
module rxfmt_parity (
	input wire logic [7:0] data,
	input wire logic [2:0] status,
	input wire logic [1:0] par_mode,
	input wire logic bypass,
	output logic parity
);

	// ----------------------------------------------------------------
	// coverage select
	// ----------------------------------------------------------------
	always_comb begin
		unique case (par_mode)
			rxfmt_pkg::LVL_HIGH: begin
				parity = ~^{status, data};
			end
			rxfmt_pkg::LVL_MID: begin
				if (bypass) begin
					parity = ~^{status[1:0], data};
				end else begin
					parity = ~^data;
				end
			end
			default: begin
				// pin is released, so the value is don't-care
				parity = 1'b0;
			end
		endcase
	end

endmodule : rxfmt_parity

// file: hw/rxfmt_top.sv
// rxfmt_top: one receive channel's output register formatter.
// assumes framer, decoder and self-test logic on the recovered clock,
// changing their outputs away from its rising edge; apb on clk.
`timescale 1ns/1ps
module rxfmt_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rec_clk,
	input wire logic [9:0] raw_char_bits,
	input wire logic [7:0] dec_char,
	input wire logic [6:0] dec_cond,
	input wire logic framing_char_detect,
	input wire logic selftest_active,
	input wire logic [2:0] selftest_status,
	output logic [7:0] rx_data_bits,
	output logic [2:0] rx_status_bits,
	output logic rx_parity_out,
	output logic rx_parity_oe_n,
	output logic rx_output_clock
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] norm_lvl(input logic [1:0] v);
		norm_lvl = (v == rxfmt_pkg::LVL_BAD) ? rxfmt_pkg::LVL_HIGH : v;
	endfunction : norm_lvl

	function automatic logic [2:0] prio_status(input logic [6:0] c);
		if (c[rxfmt_pkg::COND_PLL]) begin
			prio_status = rxfmt_pkg::ST_UNLOCK;
		end else if (c[rxfmt_pkg::COND_BUF]) begin
			prio_status = rxfmt_pkg::ST_BUF_ERR;
		end else if (c[rxfmt_pkg::COND_INVALID]) begin
			prio_status = rxfmt_pkg::ST_INVALID;
		end else if (c[rxfmt_pkg::COND_CODEV]) begin
			prio_status = rxfmt_pkg::ST_CODE_VIOL;
		end else if (c[rxfmt_pkg::COND_FRAME]) begin
			prio_status = rxfmt_pkg::ST_FRAME;
		end else if (c[rxfmt_pkg::COND_DISP]) begin
			prio_status = rxfmt_pkg::ST_DISP_ERR;
		end else if (c[rxfmt_pkg::COND_SPECIAL]) begin
			prio_status = rxfmt_pkg::ST_SPECIAL;
		end else begin
			prio_status = rxfmt_pkg::ST_NORMAL;
		end
	endfunction : prio_status

	// ----------------------------------------------------------------
	// link-side synchroniser
	// ----------------------------------------------------------------
	// data is assumed stable around the rec_clk rise, so the bundle
	// travels through the same two stages as the clock itself
	logic [rxfmt_pkg::LINK_W-1:0] link_s1_ff;
	logic [rxfmt_pkg::LINK_W-1:0] link_s2_ff;
	logic rec_d_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link_s1_ff <= '0;
			link_s2_ff <= '0;
			rec_d_ff <= 1'b0;
		end else begin
			link_s1_ff <= {rec_clk, raw_char_bits, dec_char, dec_cond,
				framing_char_detect, selftest_active, selftest_status};
			link_s2_ff <= link_s1_ff;
			rec_d_ff <= link_s2_ff[30];
		end
	end

	logic rec_s;
	logic [9:0] raw_s;
	logic [7:0] dec_s;
	logic [6:0] cond_s;
	logic frame_s;
	logic st_act_s;
	logic [2:0] st_stat_s;
	assign {rec_s, raw_s, dec_s, cond_s, frame_s, st_act_s, st_stat_s} =
		link_s2_ff;
	logic rise;
	logic fall;
	assign rise = rec_s & ~rec_d_ff;
	assign fall = ~rec_s & rec_d_ff;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] stat_word;
	logic [1:0] dec_mode, par_mode, frm_mode, cks_mode;
	logic half_rate, fen;

	assign dec_mode = ctrl_ff[rxfmt_pkg::CTRL_DEC_LSB +: 2];
	assign par_mode = ctrl_ff[rxfmt_pkg::CTRL_PAR_LSB +: 2];
	assign frm_mode = ctrl_ff[rxfmt_pkg::CTRL_FRM_LSB +: 2];
	assign cks_mode = ctrl_ff[rxfmt_pkg::CTRL_CKS_LSB +: 2];
	assign half_rate = ctrl_ff[rxfmt_pkg::CTRL_HALF_BIT];
	assign fen = ctrl_ff[rxfmt_pkg::CTRL_FEN_BIT];

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_prdata = prdata_ff;
		// answer one cycle after setup; access phase is one cycle
		nxt_pready = psel & ~penable;
		nxt_pslverr = 1'b0;
		if (psel & ~penable) begin
			nxt_pslverr = (paddr != rxfmt_pkg::CTRL_ADDR) &&
				(paddr != rxfmt_pkg::STAT_ADDR || pwrite);
			if (pwrite || nxt_pslverr) begin
				nxt_prdata = '0;
			end else if (paddr == rxfmt_pkg::CTRL_ADDR) begin
				nxt_prdata = ctrl_ff;
			end else begin
				nxt_prdata = stat_word;
			end
		end
		if (psel & penable & pready_ff & pwrite & ~pslverr_ff) begin
			nxt_ctrl = pwdata & rxfmt_pkg::CTRL_MASK;
			nxt_ctrl[rxfmt_pkg::CTRL_DEC_LSB +: 2] =
				norm_lvl(pwdata[rxfmt_pkg::CTRL_DEC_LSB +: 2]);
			nxt_ctrl[rxfmt_pkg::CTRL_PAR_LSB +: 2] =
				norm_lvl(pwdata[rxfmt_pkg::CTRL_PAR_LSB +: 2]);
			nxt_ctrl[rxfmt_pkg::CTRL_FRM_LSB +: 2] =
				norm_lvl(pwdata[rxfmt_pkg::CTRL_FRM_LSB +: 2]);
			nxt_ctrl[rxfmt_pkg::CTRL_CKS_LSB +: 2] =
				norm_lvl(pwdata[rxfmt_pkg::CTRL_CKS_LSB +: 2]);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= rxfmt_pkg::CTRL_RESET;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------------------------------
	// character formatting and alignment
	// ----------------------------------------------------------------
	logic [11:0] pipe_ff, nxt_pipe;
	logic pipe_sel_ff, nxt_pipe_sel;
	logic [7:0] data_ff, nxt_data;
	logic [2:0] st_ff, nxt_st;
	logic par_ff, nxt_par;
	logic oen_ff, nxt_oen;
	logic oclk_ff, nxt_oclk;
	logic stretch_ff, nxt_stretch;
	logic [11:0] direct;
	logic [11:0] load;
	logic bypass, rising_phase, adjust, low_lat, par_bit;

	assign bypass = (dec_mode == rxfmt_pkg::LVL_LOW);
	assign low_lat = (frm_mode == rxfmt_pkg::LVL_LOW);
	// one output clock rise per two characters in half rate
	assign rising_phase = ~half_rate | ~oclk_ff;
	assign adjust = fen & half_rate & frame_s;

	always_comb begin
		// word is {framing flag, status, data}
		direct = {frame_s, prio_status(cond_s), dec_s};
		if (st_act_s) begin
			direct[10:8] = st_stat_s;
		end else if (bypass) begin
			// status 2 is the framer's boundary-qualified match flag
			direct[10:8] = {frame_s, raw_s[0], raw_s[1]};
		end
		if (bypass) begin
			direct[7:0] = raw_s[9:2];
		end
	end

	always_comb begin
		nxt_pipe = pipe_ff;
		nxt_pipe_sel = pipe_sel_ff;
		nxt_oclk = oclk_ff;
		nxt_stretch = stretch_ff;
		nxt_oen = (par_mode == rxfmt_pkg::LVL_LOW);
		if (rise) begin
			nxt_pipe = direct;
			nxt_oclk = half_rate ? ~oclk_ff : 1'b1;
			if (adjust & ~low_lat) begin
				// the framing char lands on a rise: now, or one later
				nxt_pipe_sel = ~rising_phase;
			end
			if (adjust & low_lat & ~rising_phase &
				(cks_mode != rxfmt_pkg::LVL_LOW)) begin
				// fall now, rise mid-character with framing still held
				nxt_oclk = 1'b0;
				nxt_stretch = 1'b1;
			end
		end else if (fall) begin
			if (stretch_ff) begin
				nxt_oclk = 1'b1;
				nxt_stretch = 1'b0;
			end else if (!half_rate) begin
				nxt_oclk = 1'b0;
			end
		end
	end

	assign load = nxt_pipe_sel ? pipe_ff : direct;

	rxfmt_parity u_parity (
		.data(load[7:0]),
		.status(load[10:8]),
		.par_mode(par_mode),
		.bypass(bypass),
		.parity(par_bit)
	);

	always_comb begin
		nxt_data = data_ff;
		nxt_st = st_ff;
		nxt_par = par_ff;
		if (rise) begin
			nxt_data = load[7:0];
			nxt_st = load[10:8];
			nxt_par = par_bit;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pipe_ff <= '0;
			pipe_sel_ff <= 1'b0;
			data_ff <= '0;
			st_ff <= '0;
			par_ff <= 1'b0;
			oen_ff <= 1'b1;
			oclk_ff <= 1'b0;
			stretch_ff <= 1'b0;
		end else begin
			pipe_ff <= nxt_pipe;
			pipe_sel_ff <= nxt_pipe_sel;
			data_ff <= nxt_data;
			st_ff <= nxt_st;
			par_ff <= nxt_par;
			oen_ff <= nxt_oen;
			oclk_ff <= nxt_oclk;
			stretch_ff <= nxt_stretch;
		end
	end

	assign rx_data_bits = data_ff;
	assign rx_status_bits = st_ff;
	assign rx_parity_out = par_ff;
	assign rx_parity_oe_n = oen_ff;
	assign rx_output_clock = oclk_ff;

	always_comb begin
		stat_word = '0;
		stat_word[rxfmt_pkg::STAT_DATA_LSB +: 8] = data_ff;
		stat_word[rxfmt_pkg::STAT_ST_LSB +: 3] = st_ff;
		stat_word[rxfmt_pkg::STAT_PAR_BIT] = par_ff;
		stat_word[rxfmt_pkg::STAT_CLK_BIT] = oclk_ff;
		stat_word[rxfmt_pkg::STAT_PIPE_BIT] = pipe_sel_ff;
		stat_word[rxfmt_pkg::STAT_OEN_BIT] = oen_ff;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic load_q_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			load_q_ff <= 1'b0;
		end else begin
			load_q_ff <= rise;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	par_high_a: assert property (
		load_q_ff && $past(par_mode) == rxfmt_pkg::LVL_HIGH |->
		^{rx_status_bits, rx_data_bits, rx_parity_out})
		else $error("parity high coverage wrong");
	par_mid_dec_a: assert property (
		load_q_ff && $past(par_mode) == rxfmt_pkg::LVL_MID &&
		!$past(bypass) |-> ^{rx_data_bits, rx_parity_out})
		else $error("parity mid decoded coverage wrong");
	par_mid_byp_a: assert property (
		load_q_ff && $past(par_mode) == rxfmt_pkg::LVL_MID &&
		$past(bypass) |->
		^{rx_status_bits[1:0], rx_data_bits, rx_parity_out})
		else $error("parity mid bypass coverage wrong");
	par_off_a: assert property (
		par_mode == rxfmt_pkg::LVL_LOW |=> rx_parity_oe_n)
		else $error("parity pin driven while off");
	bypass_map_a: assert property (
		rise && !nxt_pipe_sel && bypass && !st_act_s |=>
		rx_data_bits == $past(raw_s[9:2]) &&
		rx_status_bits == {$past(frame_s), $past(raw_s[0]),
		$past(raw_s[1])})
		else $error("bypass bit mapping wrong");
	status_prio_a: assert property (
		rise && !nxt_pipe_sel && !bypass && !st_act_s &&
		cond_s[rxfmt_pkg::COND_PLL] |=>
		rx_status_bits == rxfmt_pkg::ST_UNLOCK)
		else $error("unlock not reported first");
	selftest_a: assert property (
		rise && !nxt_pipe_sel && st_act_s |=>
		rx_status_bits == $past(st_stat_s))
		else $error("self-test status not shown");
	pipe_align_a: assert property (
		rise && adjust && !low_lat |=>
		(rx_output_clock ? rx_status_bits == $past(direct[10:8]) :
		pipe_sel_ff))
		else $error("framing not aligned by pipeline");
	full_rate_a: assert property (
		rise && !half_rate |=> $rose(rx_output_clock))
		else $error("output clock not rising with update");

endmodule : rxfmt_top

// file: dv/rxfmt_host.sv
// rxfmt_host: model of the host logic that samples the output bus.
// assumes the bus is settled by the clk edge after the output clock rises.
`timescale 1ns/1ps
module rxfmt_host (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] rx_data_bits,
	input wire logic [2:0] rx_status_bits,
	input wire logic rx_parity_out,
	input wire logic rx_parity_oe_n,
	input wire logic rx_output_clock,
	output logic smp,
	output logic [12:0] word
);
	// ----------------------------------------------------------------
	// sample on the output clock rising edge
	// ----------------------------------------------------------------
	logic prev_ff;
	// the host sees the clock only through clk, so it lags one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_ff <= 1'b0;
			smp <= 1'b0;
			word <= 13'h0000;
		end else begin
			prev_ff <= rx_output_clock;
			smp <= rx_output_clock & ~prev_ff;
			if (rx_output_clock & ~prev_ff) begin
				word <= {rx_parity_oe_n, rx_parity_out, rx_status_bits,
					rx_data_bits};
			end
		end
	end
endmodule : rxfmt_host

// file: dv/test_rx_output_bus_parity_formatter.sv
// test bench: apb register checks and character stream through all decode and parity modes.
// assumes link inputs change while the link clock is low; the host model
// reports each word it samples on an output clock rise.
`timescale 1ns/1ps
module test_rx_output_bus_parity_formatter;
	`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
		n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); \
		end end
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, rec_clk;
	logic [7:0] paddr, dec_char, rx_data_bits;
	logic [31:0] pwdata, prdata, rs, rd;
	logic [9:0] raw_char_bits;
	logic [6:0] dec_cond;
	logic framing_char_detect, selftest_active, er;
	logic [2:0] selftest_status, rx_status_bits;
	logic rx_parity_out, rx_parity_oe_n, rx_output_clock, smp;
	logic [12:0] word;
	logic [1:0] dmode, pmode;
	// half-rate model: next load rises, pipeline stage held, last word
	logic ph, sel;
	logic [12:0] pe;
	logic [12:0] notes[$];
	int n_errors, checks_done, cycles;
	rxfmt_top dut (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rec_clk(rec_clk),
		.raw_char_bits(raw_char_bits), .dec_char(dec_char),
		.dec_cond(dec_cond), .framing_char_detect(framing_char_detect),
		.selftest_active(selftest_active),
		.selftest_status(selftest_status), .rx_data_bits(rx_data_bits),
		.rx_status_bits(rx_status_bits), .rx_parity_out(rx_parity_out),
		.rx_parity_oe_n(rx_parity_oe_n),
		.rx_output_clock(rx_output_clock));
	rxfmt_host u_host (.clk(clk), .rstn(rstn),
		.rx_data_bits(rx_data_bits), .rx_status_bits(rx_status_bits),
		.rx_parity_out(rx_parity_out), .rx_parity_oe_n(rx_parity_oe_n),
		.rx_output_clock(rx_output_clock), .smp(smp), .word(word));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs
	function automatic logic [2:0] prio(input logic [6:0] c);
		if (c[rxfmt_pkg::COND_PLL]) return rxfmt_pkg::ST_UNLOCK;
		if (c[rxfmt_pkg::COND_BUF]) return rxfmt_pkg::ST_BUF_ERR;
		if (c[rxfmt_pkg::COND_INVALID]) return rxfmt_pkg::ST_INVALID;
		if (c[rxfmt_pkg::COND_CODEV]) return rxfmt_pkg::ST_CODE_VIOL;
		if (c[rxfmt_pkg::COND_FRAME]) return rxfmt_pkg::ST_FRAME;
		if (c[rxfmt_pkg::COND_DISP]) return rxfmt_pkg::ST_DISP_ERR;
		if (c[rxfmt_pkg::COND_SPECIAL]) return rxfmt_pkg::ST_SPECIAL;
		return rxfmt_pkg::ST_NORMAL;
	endfunction : prio
	function automatic logic [12:0] expect_word(input logic [9:0] raw,
		input logic [7:0] dc, input logic [6:0] cd, input logic fd,
		input logic sa, input logic [2:0] sc);
		logic [7:0] d;
		logic [2:0] s;
		logic p;
		logic oen;
		d = dc;
		s = prio(cd);
		if (dmode == rxfmt_pkg::LVL_LOW) begin
			d = raw[9:2];
			s = {fd, raw[0], raw[1]};
		end
		if (sa) s = sc;
		p = 1'b0;
		oen = 1'b0;
		if (pmode == rxfmt_pkg::LVL_LOW) oen = 1'b1;
		else if (pmode == rxfmt_pkg::LVL_HIGH) p = ~^{d, s};
		else if (dmode == rxfmt_pkg::LVL_LOW) p = ~^{d, s[1:0]};
		else p = ~^d;
		return {oen, p, s, d};
	endfunction : expect_word
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdv, output logic erv);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one character per 8 clk: inputs change with the link clock fall;
	// hm 0 full rate, 1 half rate pipeline framer, 2 low-latency framer
	task automatic send_char(input int k, input int hm);
		logic [9:0] raw;
		logic [7:0] dc;
		logic [6:0] cd;
		logic fd, sa;
		logic [2:0] sc;
		logic [12:0] e;
		rs = xs(rs);
		raw = rs[9:0];
		dc = rs[17:10];
		fd = (hm == 0) ? rs[18] : (k == 2 || k == 5);
		sa = (k == 1) || (rs[21:19] == 3'h0);
		sc = rs[24:22];
		rs = xs(rs);
		cd = rs[6:0] & rs[13:7] & rs[20:14];
		@(posedge clk);
		rec_clk <= 1'b0;
		raw_char_bits <= raw;
		dec_char <= dc;
		dec_cond <= cd;
		framing_char_detect <= fd;
		selftest_active <= sa;
		selftest_status <= sc;
		e = expect_word(raw, dc, cd, fd, sa, sc);
		if (hm == 0) begin
			notes.push_back(e);
		end else begin
			// framing met on a fall is held one stage for the next rise
			if (hm == 1 && fd) sel = ~ph;
			// only loads on an output clock rise reach the host
			if (ph || (hm == 2 && fd)) begin
				notes.push_back(sel ? pe : e);
			end
			ph = (hm == 2 && fd) ? 1'b0 : ~ph;
		end
		pe = e;
		repeat (4) @(posedge clk);
		rec_clk <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : send_char
	task complete_run;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// ----------------------------------------------------------------
	// clock, watchdog, output monitor
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	always @(posedge clk) begin
		if (smp === 1'b1) begin
			if (notes.size() == 0) `CHK(1'b0, 1'b1)
			else `CHK(word, notes.pop_front())
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rs = 32'h0000_4A2F;
		{rstn, psel, penable, pwrite, rec_clk} = 5'h00;
		{paddr, pwdata, raw_char_bits, dec_char} = 58'h0;
		{dec_cond, framing_char_detect, selftest_active} = 9'h000;
		selftest_status = 3'h0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, rxfmt_pkg::CTRL_ADDR, 32'h0, rd, er);
		`CHK({er, rd}, {1'b0, rxfmt_pkg::CTRL_RESET})
		apb(1'b1, rxfmt_pkg::CTRL_ADDR, 32'h0000_00D5, rd, er);
		apb(1'b0, rxfmt_pkg::CTRL_ADDR, 32'h0, rd, er);
		`CHK(rd, 32'h0000_0095)
		apb(1'b0, 8'h08, 32'h0, rd, er);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, rxfmt_pkg::STAT_ADDR, 32'hFFFF_FFFF, rd, er);
		`CHK(er, 1'b1)
		$display("test registers done");
		for (int m = 0; m < 9; m++) begin
			dmode = 2'(m % 3);
			pmode = 2'(m / 3);
			apb(1'b1, rxfmt_pkg::CTRL_ADDR, {24'h0, 2'h1, 2'h1, pmode,
				dmode}, rd, er);
			for (int k = 0; k < 8; k++) send_char(k, 0);
			for (int i = 0; i < 40 && notes.size() != 0; i++) begin
				@(posedge clk);
			end
			`CHK(notes.size() == 0, 1'b1)
			$display("test dec %0d par %0d done", dmode, pmode);
		end
		// full rate holds the output clock high until the link clock falls
		apb(1'b0, rxfmt_pkg::STAT_ADDR, 32'h0, rd, er);
		`CHK({er, rd[rxfmt_pkg::STAT_CLK_BIT +: 3]}, 4'h1)
		`CHK(rd[rxfmt_pkg::STAT_DATA_LSB +: 12], word[11:0])
		$display("test status register done");
		dmode = rxfmt_pkg::LVL_LOW;
		pmode = rxfmt_pkg::LVL_HIGH;
		{ph, sel} = 2'b00;
		for (int h = 1; h < 3; h++) begin
			// framer on, half rate, clock source mid; h 2 low latency
			apb(1'b1, rxfmt_pkg::CTRL_ADDR, {22'h0, 1'b1, 1'b1, 2'h1,
				(h == 1) ? 2'h1 : 2'h0, pmode, dmode}, rd, er);
			for (int k = 0; k < 8; k++) send_char(k, h);
			for (int i = 0; i < 40 && notes.size() != 0; i++) begin
				@(posedge clk);
			end
			`CHK(notes.size() == 0, 1'b1)
			$display("test half rate %0d done", h);
		end
		complete_run();
	end
endmodule : test_rx_output_bus_parity_formatter
